// *** dv/astc_assertions.sv ***
// Port checker of the sequence trigger control block.
// Assumes one clk_sys domain and a SAMPLE_CYC of 16.
`timescale 1ns/1ps
module astc_assertions #(
    parameter int SAMPLE_CYC = 16
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic sync_release_out,
    input wire astc_pkg::astc_conv_cmd_t conv_cmd,
    input wire logic [1:0] ref_sel,
    input wire logic res_sel,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////////
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_wr(logic [7:0] a);
        s_take ##0 wb_we_i && wb_adr_i[7:0] == a && wb_sel_i == 4'hF;
    endsequence

    property p_ack_take;
        s_take |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_take: assert property (p_ack_take) else $error("ack timing");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
    property p_irq_mask;
        s_wr(astc_pkg::ADDR_INT_EN) ##0 wb_dat_i[3:0] == 4'h0 |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    property p_ref;
        s_wr(astc_pkg::ADDR_REF_SEL) ##0 wb_dat_i[1:0] != 2'h3 |=> ref_sel == $past(wb_dat_i[1:0]);
    endproperty
    a_ref: assert property (p_ref) else $error("ref not taken");
    property p_ref_bad;
        s_wr(astc_pkg::ADDR_REF_SEL) ##0 wb_dat_i[1:0] == 2'h3 |=> $stable(ref_sel);
    endproperty
    a_ref_bad: assert property (p_ref_bad) else $error("ref code 3 taken");
    property p_res;
        s_wr(astc_pkg::ADDR_RES_SEL) |=> res_sel == $past(wb_dat_i[0]);
    endproperty
    a_res: assert property (p_res) else $error("res not taken");
    property p_rel;
        s_wr(astc_pkg::ADDR_SW_TRIG) ##0 wb_dat_i[9] |=> sync_release_out ##1 !sync_release_out;
    endproperty
    a_rel: assert property (p_rel) else $error("no release pulse");
    property p_start_delay;
        $rose(conv_cmd.busy) |-> ##[1:16] conv_cmd.start;
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("start late");
    property p_start_step;
        conv_cmd.start |-> conv_cmd.busy && (conv_cmd.seq == 2'h3 ? conv_cmd.step == 3'h0 :
            conv_cmd.seq == 2'h0 || conv_cmd.step <= 3'h3);
    endproperty
    a_start_step: assert property (p_start_step) else $error("step beyond depth");
    // A step lasts at least half a sample period
    property p_step_gap;
        conv_cmd.start |=> (!conv_cmd.start) [*8];
    endproperty
    a_step_gap: assert property (p_step_gap) else $error("starts too close");
endmodule : astc_assertions

bind astc_top astc_assertions #(.SAMPLE_CYC(SAMPLE_CYC)) i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sync_release_out(sync_release_out),
    .conv_cmd(conv_cmd), .ref_sel(ref_sel), .res_sel(res_sel), .irq(irq));

// *** dv/astc_top_tb.sv ***
// Self-checking bench of the sequence trigger control block.
// Assumes the trigger source model and the bound port checker.
`timescale 1ns/1ps
module astc_top_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic rel_out, irq, res_sel;
    logic [1:0] ref_sel, last_seq;
    logic [3:0] drained;
    logic rel_in;
    astc_pkg::astc_trig_in_t trig;
    astc_pkg::astc_conv_cmd_t cmd;
    logic [3:0] dep [4] = '{astc_pkg::DEPTH_SEQ0, astc_pkg::DEPTH_SEQ1, astc_pkg::DEPTH_SEQ2, astc_pkg::DEPTH_SEQ3};
    int error_cnt = 0, checked = 0, cyc_cnt = 0, n;

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    astc_top #(.SAMPLE_CYC(16)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .trig_in(trig), .fifo_drained(drained), .sync_release_in(rel_in), .sync_release_out(rel_out),
        .conv_cmd(cmd), .ref_sel(ref_sel), .res_sel(res_sel), .irq(irq));
    astc_trig_src i_src (.clk_sys(clk_sys), .trig_in(trig), .fifo_drained(drained), .sync_release_in(rel_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (error_cnt == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {24'h0, a};
        wdat <= d;
        do begin
            @(posedge clk_sys);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(nm, q, e);
    endtask : rd
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask : tick
    // Counts the step starts of one run
    task automatic run_cnt(output int c);
        c = 0;
        while (cmd.busy !== 1'b1) begin
            tick();
        end
        while (cmd.busy === 1'b1) begin
            if (cmd.start === 1'b1) begin
                c++;
                last_seq = cmd.seq;
            end
            tick();
        end
    endtask : run_cnt

    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 30000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd("priority", astc_pkg::ADDR_PRIORITY, 32'hE4);
        rd("phase", astc_pkg::ADDR_PHASE, 32'h0);
        rd("unmapped", 8'h3C, 32'h0);
        for (int r = 0; r < 4; r++) begin
            wr(astc_pkg::ADDR_REF_SEL, r);
            rd("ref", astc_pkg::ADDR_REF_SEL, (r == 3) ? 2 : r);
        end
        for (int r = 1; r >= 0; r--) begin
            wr(astc_pkg::ADDR_RES_SEL, r);
            rd("res", astc_pkg::ADDR_RES_SEL, r);
        end
        wr(astc_pkg::ADDR_SEQ_EN, 32'hF);
        for (int s = 0; s < 4; s++) begin
            wr(astc_pkg::ADDR_SW_TRIG, 32'h1 << s);
            run_cnt(n);
            chk("depth", n, dep[s]);
            chk("seq", last_seq, s);
            i_src.drain(s);
        end
        wr(astc_pkg::ADDR_PRIORITY, 32'h27);
        wr(astc_pkg::ADDR_SW_TRIG, 32'h9);
        run_cnt(n);
        chk("first seq", last_seq, 3);
        run_cnt(n);
        chk("second run", n, 8);
        i_src.drain(0);
        wr(astc_pkg::ADDR_PRIORITY, 32'hE4);
        wr(astc_pkg::ADDR_INT_CLR, 32'hF);
        wr(astc_pkg::ADDR_INT_EN, 32'h0);
        wr(astc_pkg::ADDR_SW_TRIG, 32'h8);
        run_cnt(n);
        rd("raw", astc_pkg::ADDR_INT_RAW, 32'h8);
        rd("masked", astc_pkg::ADDR_INT_MASKED, 32'h0);
        wr(astc_pkg::ADDR_INT_EN, 32'h8);
        rd("raw stale", astc_pkg::ADDR_INT_RAW, 32'h0);
        chk("irq stale", irq, 1'b0);
        wr(astc_pkg::ADDR_SW_TRIG, 32'h8);
        run_cnt(n);
        rd("masked", astc_pkg::ADDR_INT_MASKED, 32'h8);
        chk("irq", irq, 1'b1);
        rd("ovf", astc_pkg::ADDR_OVF, 32'h8);
        wr(astc_pkg::ADDR_INT_CLR, 32'h8);
        wr(astc_pkg::ADDR_OVF_CLR, 32'h8);
        chk("irq clr", irq, 1'b0);
        rd("ovf clr", astc_pkg::ADDR_OVF, 32'h0);
        i_src.drain(3);
        wr(astc_pkg::ADDR_SEQ_EN, 32'h0);
        wr(astc_pkg::ADDR_SW_TRIG, 32'h8);
        repeat (6) tick();
        chk("disabled", cmd.busy, 1'b0);
        wr(astc_pkg::ADDR_TRIG_SEL, 32'h50);
        wr(astc_pkg::ADDR_SEQ_EN, 32'h2);
        wr(astc_pkg::ADDR_SW_TRIG, 32'h2);
        repeat (6) tick();
        chk("sw ignored", cmd.busy, 1'b0);
        for (int c = 1; c < 10; c++) begin
            wr(astc_pkg::ADDR_SEQ_EN, 32'h0);
            wr(astc_pkg::ADDR_TRIG_SEL, c << 12);
            wr(astc_pkg::ADDR_SEQ_EN, 32'h8);
            i_src.fire(c - 1);
            run_cnt(n);
            chk("source", n, 1);
            i_src.drain(3);
        end
        wr(astc_pkg::ADDR_SEQ_EN, 32'h0);
        wr(astc_pkg::ADDR_TRIG_SEL, 32'h0);
        wr(astc_pkg::ADDR_SEQ_EN, 32'hF);
        wr(astc_pkg::ADDR_SW_TRIG, 32'h108);
        repeat (6) tick();
        chk("held", cmd.busy, 1'b0);
        i_src.release_all();
        run_cnt(n);
        chk("released", n, 1);
        i_src.drain(3);
        wr(astc_pkg::ADDR_SW_TRIG, 32'h200);
        for (int k = 0; k < 3; k++) begin
            wr(astc_pkg::ADDR_PHASE, (k == 2) ? 15 : k * 4);
            rd("phase", astc_pkg::ADDR_PHASE, (k == 2) ? 15 : k * 4);
            wr(astc_pkg::ADDR_SW_TRIG, (k == 1) ? 32'h1 : 32'h8);
            n = 0;
            do begin
                tick();
                n++;
            end while (cmd.start !== 1'b1 && n < 40);
            chk("delay", n, ((k == 2) ? 15 : k * 4) + 1);
            run_cnt(n);
            i_src.drain((k == 1) ? 0 : 3);
        end
        wr(astc_pkg::ADDR_PHASE, 32'h0);
        wr(astc_pkg::ADDR_SEQ_EN, 32'h0);
        wr(astc_pkg::ADDR_TRIG_SEL, 32'hA00);
        wr(astc_pkg::ADDR_SEQ_EN, 32'h5);
        run_cnt(n);
        run_cnt(n);
        chk("repeat", last_seq, 2);
        wr(astc_pkg::ADDR_SW_TRIG, 32'h1);
        run_cnt(n);
        if (last_seq !== 2'h0) begin
            run_cnt(n);
        end
        chk("yield", last_seq, 0);
        finish_test();
    end
endmodule : astc_top_tb

// *** dv/astc_trig_src.sv ***
// Model of the on-chip trigger sources, the sample reader and the sibling converter.
// Assumes the bench calls its tasks; changes land just after a rising edge.
`timescale 1ns/1ps
module astc_trig_src (
    input wire logic clk_sys,
    output astc_pkg::astc_trig_in_t trig_in,
    output logic [3:0] fifo_drained,
    output logic sync_release_in
);
    logic [8:0] lvl_reg = 9'h000;
    assign trig_in = astc_pkg::astc_trig_in_t'(lvl_reg);
    initial begin
        fifo_drained = 4'h0;
        sync_release_in = 1'b0;
    end
    // Source levels stay up two cycles, as a real timer or comparator output would
    task automatic fire(input int b);
        @(posedge clk_sys);
        lvl_reg[b] <= 1'b1;
        repeat (2) @(posedge clk_sys);
        lvl_reg <= 9'h000;
    endtask : fire
    task automatic drain(input int s);
        @(posedge clk_sys);
        fifo_drained[s] <= 1'b1;
        @(posedge clk_sys);
        fifo_drained <= 4'h0;
    endtask : drain
    task automatic release_all;
        @(posedge clk_sys);
        sync_release_in <= 1'b1;
        @(posedge clk_sys);
        sync_release_in <= 1'b0;
    endtask : release_all
endmodule : astc_trig_src

// *** pkg/astc_pkg.sv ***
// Shared constants and types of the converter sequence trigger control block.
// Assumes a classic Wishbone master with 32-bit data and on-chip trigger sources in the clk_sys domain.
package astc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Geometry and timing
    localparam int NUM_SEQ = 4;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SAMPLE_PERIOD_NS = 640;
    localparam int SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PHASE_STEP_TENTH_DEG = 225;
    localparam int PHASE_MAX_TENTH_DEG = 3375;
    localparam int PHASE_SETTINGS = PHASE_MAX_TENTH_DEG / PHASE_STEP_TENTH_DEG + 1;
    localparam logic [3:0] DEPTH_SEQ0 = 4'h8;
    localparam logic [3:0] DEPTH_SEQ1 = 4'h4;
    localparam logic [3:0] DEPTH_SEQ2 = 4'h4;
    localparam logic [3:0] DEPTH_SEQ3 = 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] ADDR_SEQ_EN = 8'h00;
    localparam logic [7:0] ADDR_TRIG_SEL = 8'h04;
    localparam logic [7:0] ADDR_PRIORITY = 8'h08;
    localparam logic [7:0] ADDR_PHASE = 8'h0C;
    localparam logic [7:0] ADDR_SW_TRIG = 8'h10;
    localparam logic [7:0] ADDR_REF_SEL = 8'h14;
    localparam logic [7:0] ADDR_RES_SEL = 8'h18;
    localparam logic [7:0] ADDR_INT_RAW = 8'h1C;
    localparam logic [7:0] ADDR_INT_EN = 8'h20;
    localparam logic [7:0] ADDR_INT_MASKED = 8'h24;
    localparam logic [7:0] ADDR_INT_CLR = 8'h28;
    localparam logic [7:0] ADDR_OVF = 8'h2C;
    localparam logic [7:0] ADDR_OVF_CLR = 8'h30;
    localparam logic [7:0] ADDR_STATUS = 8'h34;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int SW_TRIG_HOLD_BIT = 8;
    localparam int SW_TRIG_RELEASE_BIT = 9;
    localparam int TRIG_SEL_FIELD_W = 4;
    localparam int PRIO_FIELD_W = 2;
    localparam logic [15:0] TRIG_SEL_RESET = 16'h0000;
    localparam logic [7:0] PRIORITY_RESET = 8'hE4;
    localparam logic [3:0] PHASE_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Trigger source codes
    localparam logic [3:0] TRIG_SRC_PROCESSOR = 4'h0;
    localparam logic [3:0] TRIG_SRC_ANALOG_CMP_FIRST = 4'h1;
    localparam logic [3:0] TRIG_SRC_ANALOG_CMP_SECOND = 4'h2;
    localparam logic [3:0] TRIG_SRC_ANALOG_CMP_THIRD = 4'h3;
    localparam logic [3:0] TRIG_SRC_EXT_PIN = 4'h4;
    localparam logic [3:0] TRIG_SRC_TIMER = 4'h5;
    localparam logic [3:0] TRIG_SRC_PULSE_GEN_FIRST = 4'h6;
    localparam logic [3:0] TRIG_SRC_PULSE_GEN_SECOND = 4'h7;
    localparam logic [3:0] TRIG_SRC_PULSE_GEN_THIRD = 4'h8;
    localparam logic [3:0] TRIG_SRC_PULSE_GEN_FOURTH = 4'h9;
    localparam logic [3:0] TRIG_SRC_ALWAYS = 4'hA;

    // Reference and resolution codes
    localparam logic [1:0] REF_INTERNAL = 2'h0;
    localparam logic [1:0] REF_EXTERNAL_HIGH = 2'h1;
    localparam logic [1:0] REF_EXTERNAL_LOW = 2'h2;
    localparam logic RES_TWELVE_BIT = 1'b0;
    localparam logic RES_TEN_BIT = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [3:0] pulse_gen;
        logic timer;
        logic ext_pin;
        logic [2:0] analog_cmp;
    } astc_trig_in_t;

    typedef struct packed {
        logic busy;
        logic start;
        logic [1:0] seq;
        logic [2:0] step;
    } astc_conv_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_SAMPLE = 2'b10
    } astc_state_t;

endpackage : astc_pkg

// *** rtl/astc_top.sv ***
// Sequence trigger control: trigger selection, priority arbitration, phase delay and sequence interrupts.
// Assumes a classic Wishbone master, trigger sources and FIFO drain pulses synchronous to clk_sys.
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module astc_top #(
    parameter int SAMPLE_CYC = astc_pkg::SAMPLE_PERIOD_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire astc_pkg::astc_trig_in_t trig_in,
    input wire logic [3:0] fifo_drained,
    input wire logic sync_release_in,
    output logic sync_release_out,
    output astc_pkg::astc_conv_cmd_t conv_cmd,
    output logic [1:0] ref_sel,
    output logic res_sel,
    output logic irq
);

    initial begin
        if (SAMPLE_CYC < astc_pkg::PHASE_SETTINGS || (SAMPLE_CYC % astc_pkg::PHASE_SETTINGS) != 0
            || SAMPLE_CYC > 65535) begin
            $error("SAMPLE_CYC must be a multiple of the phase setting count and fit 16 bits");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : byte_mask

    function automatic logic [3:0] seq_depth(input logic [1:0] idx);
        case (idx)
            2'h0: seq_depth = astc_pkg::DEPTH_SEQ0;
            2'h1: seq_depth = astc_pkg::DEPTH_SEQ1;
            2'h2: seq_depth = astc_pkg::DEPTH_SEQ2;
            default: seq_depth = astc_pkg::DEPTH_SEQ3;
        endcase
    endfunction : seq_depth

    function automatic logic src_level(input logic [3:0] code, input astc_pkg::astc_trig_in_t t);
        case (code)
            astc_pkg::TRIG_SRC_ANALOG_CMP_FIRST: src_level = t.analog_cmp[0];
            astc_pkg::TRIG_SRC_ANALOG_CMP_SECOND: src_level = t.analog_cmp[1];
            astc_pkg::TRIG_SRC_ANALOG_CMP_THIRD: src_level = t.analog_cmp[2];
            astc_pkg::TRIG_SRC_EXT_PIN: src_level = t.ext_pin;
            astc_pkg::TRIG_SRC_TIMER: src_level = t.timer;
            astc_pkg::TRIG_SRC_PULSE_GEN_FIRST: src_level = t.pulse_gen[0];
            astc_pkg::TRIG_SRC_PULSE_GEN_SECOND: src_level = t.pulse_gen[1];
            astc_pkg::TRIG_SRC_PULSE_GEN_THIRD: src_level = t.pulse_gen[2];
            astc_pkg::TRIG_SRC_PULSE_GEN_FOURTH: src_level = t.pulse_gen[3];
            default: src_level = 1'b0;
        endcase
    endfunction : src_level

    // Ties go to the lower index; unique priorities are software's job
    function automatic logic [1:0] pick_seq(input logic [3:0] pend, input logic [7:0] prio);
        logic [1:0] best;
        logic [2:0] best_val;
        best = 2'h0;
        best_val = 3'h4;
        for (int i = 0; i < astc_pkg::NUM_SEQ; i++) begin
            if (pend[i] && {1'b0, prio[2*i +: 2]} < best_val) begin
                best = 2'(i);
                best_val = {1'b0, prio[2*i +: 2]};
            end
        end
        pick_seq = best;
    endfunction : pick_seq

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [3:0] seq_en_reg;
    logic [15:0] trig_sel_reg;
    logic [7:0] prio_reg;
    logic [3:0] phase_reg;
    logic [1:0] ref_reg;
    logic res_reg;
    logic [3:0] int_raw_reg;
    logic [3:0] int_en_reg;
    logic [3:0] ovf_reg;
    logic [3:0] pend_reg;
    logic [3:0] held_reg;
    logic [3:0] unread_reg;
    logic [3:0] lvl_prev_reg;
    logic sync_out_reg;
    astc_pkg::astc_state_t state_reg;
    logic [15:0] cnt_reg;
    logic [1:0] cur_seq_reg;
    logic [2:0] step_reg;
    logic start_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire logic req = wb_cyc_i && wb_stb_i && !ack_reg;
    wire logic wr = req && wb_we_i;
    wire logic [7:0] off = wb_adr_i[7:0];
    wire logic [31:0] wmask = byte_mask(wb_sel_i);
    wire logic [31:0] wdat = wb_dat_i & wmask;
    wire logic wr_seq_en = wr && off == astc_pkg::ADDR_SEQ_EN;
    wire logic wr_trig_sel = wr && off == astc_pkg::ADDR_TRIG_SEL;
    wire logic wr_prio = wr && off == astc_pkg::ADDR_PRIORITY;
    wire logic wr_phase = wr && off == astc_pkg::ADDR_PHASE;
    wire logic wr_sw_trig = wr && off == astc_pkg::ADDR_SW_TRIG;
    wire logic wr_ref = wr && off == astc_pkg::ADDR_REF_SEL && wb_sel_i[0];
    wire logic wr_res = wr && off == astc_pkg::ADDR_RES_SEL && wb_sel_i[0];
    wire logic wr_int_en = wr && off == astc_pkg::ADDR_INT_EN && wb_sel_i[0];
    wire logic wr_int_clr = wr && off == astc_pkg::ADDR_INT_CLR && wb_sel_i[0];
    wire logic wr_ovf_clr = wr && off == astc_pkg::ADDR_OVF_CLR && wb_sel_i[0];
    wire logic [3:0] sw_mask = wdat[3:0];
    wire logic sw_hold = wdat[astc_pkg::SW_TRIG_HOLD_BIT];
    wire logic sw_release = wdat[astc_pkg::SW_TRIG_RELEASE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Trigger detection
    wire logic idle = state_reg == astc_pkg::ST_IDLE;
    wire logic [1:0] grant_seq = pick_seq(pend_reg, prio_reg);
    wire logic grant = idle && |pend_reg;
    wire logic done = state_reg == astc_pkg::ST_SAMPLE && cnt_reg == 16'h0000
        && {1'b0, step_reg} == seq_depth(cur_seq_reg) - 4'h1;
    logic [3:0] lvl_now;
    logic [3:0] trig_evt;
    logic [3:0] hold_set;
    logic [3:0] active_seq;

    always_comb begin
        for (int i = 0; i < astc_pkg::NUM_SEQ; i++) begin
            logic [3:0] code;
            logic is_proc;
            logic hw_evt;
            logic sw_evt;
            hw_evt = 1'b0;
            code = trig_sel_reg[4*i +: 4];
            is_proc = code == astc_pkg::TRIG_SRC_PROCESSOR;
            active_seq[i] = !idle && cur_seq_reg == 2'(i);
            lvl_now[i] = src_level(code, trig_in);
            if (code == astc_pkg::TRIG_SRC_ALWAYS) begin
                hw_evt = !pend_reg[i] && !active_seq[i];
            end else begin
                hw_evt = lvl_now[i] && !lvl_prev_reg[i];
            end
            sw_evt = is_proc && ((wr_sw_trig && sw_mask[i] && !sw_hold)
                || (sync_release_in && held_reg[i]));
            hold_set[i] = wr_sw_trig && sw_mask[i] && sw_hold && is_proc;
            trig_evt[i] = seq_en_reg[i] && (hw_evt || sw_evt);
        end
    end

    // Phase delay in clocks: setting times one sixteenth of the sample period
    wire logic [19:0] delay_full = {16'h0000, phase_reg} * 20'(SAMPLE_CYC / astc_pkg::PHASE_SETTINGS);
    wire logic [15:0] delay_cyc = delay_full[15:0];
    wire logic [15:0] sample_last = 16'(SAMPLE_CYC - 1);
    wire logic [3:0] done_vec = done ? (4'h1 << cur_seq_reg) : 4'h0;
    wire logic [3:0] grant_vec = grant ? (4'h1 << grant_seq) : 4'h0;
    wire logic [3:0] int_en_rise = wr_int_en ? (wdat[3:0] & ~int_en_reg) : 4'h0;
    wire logic [3:0] int_masked = int_raw_reg & int_en_reg;
    wire logic [15:0] trig_sel_next = (trig_sel_reg & ~wmask[15:0]) | wdat[15:0];
    wire logic [7:0] prio_next = (prio_reg & ~wmask[7:0]) | wdat[7:0];
    wire logic ref_ok = wdat[1:0] != 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        case (off)
            astc_pkg::ADDR_SEQ_EN: rd_mux = {28'h0000000, seq_en_reg};
            astc_pkg::ADDR_TRIG_SEL: rd_mux = {16'h0000, trig_sel_reg};
            astc_pkg::ADDR_PRIORITY: rd_mux = {24'h000000, prio_reg};
            astc_pkg::ADDR_PHASE: rd_mux = {28'h0000000, phase_reg};
            astc_pkg::ADDR_REF_SEL: rd_mux = {30'h00000000, ref_reg};
            astc_pkg::ADDR_RES_SEL: rd_mux = {31'h00000000, res_reg};
            astc_pkg::ADDR_INT_RAW: rd_mux = {28'h0000000, int_raw_reg};
            astc_pkg::ADDR_INT_EN: rd_mux = {28'h0000000, int_en_reg};
            astc_pkg::ADDR_INT_MASKED: rd_mux = {28'h0000000, int_masked};
            astc_pkg::ADDR_OVF: rd_mux = {28'h0000000, ovf_reg};
            astc_pkg::ADDR_STATUS: rd_mux = {17'h00000, cur_seq_reg, !idle, unread_reg, held_reg, pend_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave and configuration
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            seq_en_reg <= 4'h0;
            trig_sel_reg <= astc_pkg::TRIG_SEL_RESET;
            prio_reg <= astc_pkg::PRIORITY_RESET;
            phase_reg <= astc_pkg::PHASE_RESET;
            ref_reg <= astc_pkg::REF_INTERNAL;
            res_reg <= astc_pkg::RES_TWELVE_BIT;
            int_en_reg <= 4'h0;
            sync_out_reg <= 1'b0;
        end else begin
            ack_reg <= req;
            rdata_reg <= req ? rd_mux : 32'h00000000;
            sync_out_reg <= wr_sw_trig && sw_release;
            if (wr_seq_en) begin
                seq_en_reg <= (seq_en_reg & ~wmask[3:0]) | wdat[3:0];
            end
            if (wr_trig_sel) begin
                trig_sel_reg <= trig_sel_next;
            end
            if (wr_prio) begin
                prio_reg <= prio_next;
            end
            if (wr_phase && wb_sel_i[0]) begin
                phase_reg <= wdat[3:0];
            end
            // The unused code is refused so the analog front end never sees it
            if (wr_ref && ref_ok) begin
                ref_reg <= wdat[1:0];
            end
            if (wr_res) begin
                res_reg <= wdat[0];
            end
            if (wr_int_en) begin
                int_en_reg <= wdat[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger bookkeeping; hardware set wins over software clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            int_raw_reg <= 4'h0;
            ovf_reg <= 4'h0;
            pend_reg <= 4'h0;
            held_reg <= 4'h0;
            unread_reg <= 4'h0;
            lvl_prev_reg <= 4'h0;
        end else begin
            lvl_prev_reg <= lvl_now;
            int_raw_reg <= (int_raw_reg & ~int_en_rise & ~(wr_int_clr ? wdat[3:0] : 4'h0)) | done_vec;
            ovf_reg <= (ovf_reg & ~(wr_ovf_clr ? wdat[3:0] : 4'h0)) | (trig_evt & unread_reg);
            pend_reg <= ((pend_reg & ~grant_vec) | trig_evt) & seq_en_reg;
            held_reg <= (held_reg & ~(sync_release_in ? 4'hF : 4'h0)) | hold_set;
            unread_reg <= (unread_reg & ~fifo_drained) | done_vec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequence engine
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= astc_pkg::ST_IDLE;
            cnt_reg <= 16'h0000;
            cur_seq_reg <= 2'h0;
            step_reg <= 3'h0;
            start_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            case (state_reg)
                astc_pkg::ST_IDLE: begin
                    if (grant) begin
                        cur_seq_reg <= grant_seq;
                        cnt_reg <= delay_cyc;
                        state_reg <= astc_pkg::ST_DELAY;
                    end
                end
                astc_pkg::ST_DELAY: begin
                    if (cnt_reg == 16'h0000) begin
                        step_reg <= 3'h0;
                        cnt_reg <= sample_last;
                        start_reg <= 1'b1;
                        state_reg <= astc_pkg::ST_SAMPLE;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                astc_pkg::ST_SAMPLE: begin
                    if (done) begin
                        state_reg <= astc_pkg::ST_IDLE;
                    end else if (cnt_reg == 16'h0000) begin
                        step_reg <= step_reg + 3'h1;
                        cnt_reg <= sample_last;
                        start_reg <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                default: state_reg <= astc_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign sync_release_out = sync_out_reg;
    assign ref_sel = ref_reg;
    assign res_sel = res_reg;
    assign irq = |int_masked;
    assign conv_cmd.busy = !idle;
    assign conv_cmd.start = start_reg;
    assign conv_cmd.seq = cur_seq_reg;
    assign conv_cmd.step = step_reg;

endmodule : astc_top
